// file: hw/power_mode_pad_state_control.sv
// Pad state controller: forces pad drive and input masking per power condition.
// Assumes clk is the bus clock, arst_n the reset pin, and susp_clk a free-running suspend clock.
//
// What this block does
// - During slow refresh only display-memory refresh runs and all other memory activity is blocked.
// - In slow refresh a CAS-before-RAS refresh cycle is issued once every 30 microseconds.
// - A sustained-tristate low-active signal has exactly one driver at a time.
// - A driver releasing a sustained-tristate line it drove low drives it high one clock before floating.
// - No agent starts driving a sustained-tristate line sooner than one clock after the previous release.
// - Inputs ignored in a power condition are forced internally high.
// - Column strobes slow-refresh in both suspends, work in standby and stay high in reset.
// - Write strobes work in standby and stay high in hardware suspend, software suspend and reset.
// - Interrupt and target-response outputs float in hardware suspend and reset, work otherwise.
// - The oscillator input is ignored in suspend when an external 32 kHz clock is used.
// - With self-refresh DRAMs all column and row strobes are held low in both suspends.
// - Video-port inputs are ignored while its enable bit is 0; mode 001 must be set before enabling.
// - Four pad conditions are told apart: standby, hardware suspend, software suspend and reset.
`timescale 1ns/100ps
`default_nettype none
module power_mode_pad_state_control
    import pad_state_pkg::*;
(
    input  wire logic                clk,            // Bus clock.
    input  wire logic                arst_n,         // Reset pin, active low.
    input  wire logic                ce,             // Clock enable.
    input  wire logic                susp_clk,       // External suspend clock.
    input  wire logic                sw_standby,     // Software standby request.
    input  wire logic                sw_suspend,     // Software suspend request.
    input  wire logic                hw_suspend_pin, // Hardware suspend pin.
    input  wire logic                ext_32k_used,   // External suspend clock in use.
    input  wire logic                self_refresh,   // Self-refresh DRAMs fitted.
    input  wire logic                video_port_enable_bit, // Video-port enable.
    input  wire logic [2:0]          video_port_mode_field, // Video-port mode.
    input  wire logic [7:0]          video_port_pins,       // Raw video-port inputs.
    output logic [7:0]               video_port_in,         // Masked video-port inputs.
    input  wire logic                reference_oscillator_in, // Oscillator pin.
    output logic                     osc_in,          // Masked oscillator.
    input  wire logic [3:0]          bus_ctl_pins,    // Raw bus control inputs.
    output logic [3:0]               bus_ctl_in,      // Masked bus control inputs.
    input  wire logic [1:0]          core_cas_n,      // Core column strobes.
    input  wire logic                core_ras_n,      // Core row strobe.
    input  wire logic [1:0]          core_we_n,       // Core write strobes.
    input  wire logic                core_mem_req,    // Core memory access request.
    output logic                     mem_req_gated,   // Request allowed to memory.
    output logic [1:0]               column_strobe_n, // Column strobe pads (hi, lo).
    output logic                     row_strobe_n,    // Row strobe pad.
    output logic [1:0]               write_strobe_n,  // Write strobe pads.
    input  wire logic                core_host_interrupt_n,       // Core interrupt request.
    output logic                     host_interrupt_n,    // Interrupt pad level.
    output logic                     host_interrupt_oe_n, // Interrupt pad enable, low drives.
    input  wire logic [2:0]          core_resp_n,     // Core target responses.
    input  wire logic                core_resp_drive, // Core wants to drive responses.
    output logic [2:0]               resp_n,          // Target response pad levels.
    output logic                     resp_oe_n,       // Target response enable, low drives.
    output logic                     susp_heartbeat,  // Toggle seen from suspend clock.
    output var pad_state_pkg::pad_mode_t pad_mode     // Registered pad condition.
);
    import pad_state_pkg::*;

    // Two-flop synchronisers for pin-level inputs.
    logic [1:0] hws_sync_q;
    logic [1:0] ext_sync_q;
    logic [1:0] sr_sync_q;
    logic [2:0] beat_sync_q;
    logic [1:0] osc_sync_q;
    // The video-port pins belong to an outside pixel clock, so they are resynchronised before masking.
    logic [7:0] vport_meta_q;
    logic [7:0] vport_sync_q;
    logic       susp_toggle_q;
    pad_mode_t  mode_q;
    logic       hw_susp_q;
    logic       sw_susp_q;
    logic       resp_release_q;
    logic       resp_drive_q;
    logic       resp_gap_q;
    logic [2:0] resp_hold_q;

    // Suspend-clock domain: a toggle shows that the suspend timebase is alive.
    always_ff @(posedge susp_clk or negedge arst_n) begin
        if (!arst_n) susp_toggle_q <= 1'b0;
        else         susp_toggle_q <= ~susp_toggle_q;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hws_sync_q  <= '0;
            ext_sync_q  <= '0;
            sr_sync_q   <= '0;
            beat_sync_q <= '0;
            osc_sync_q  <= '0;
            vport_meta_q <= '0;
            vport_sync_q <= '0;
        end else if (ce) begin
            hws_sync_q  <= {hws_sync_q[0], hw_suspend_pin};
            ext_sync_q  <= {ext_sync_q[0], ext_32k_used};
            sr_sync_q   <= {sr_sync_q[0], self_refresh};
            beat_sync_q <= {beat_sync_q[1:0], susp_toggle_q};
            osc_sync_q  <= {osc_sync_q[0], reference_oscillator_in};
            vport_meta_q <= video_port_pins;
            vport_sync_q <= vport_meta_q;
        end
    end

    assign susp_heartbeat = beat_sync_q[2] ^ beat_sync_q[1];

    // Hardware suspend outranks software suspend, which outranks standby.
    wire       hw_susp_d = hws_sync_q[1];
    wire       sw_susp_d = sw_suspend && !hw_susp_d;
    pad_mode_t mode_d;
    assign mode_d = (hw_susp_d || sw_susp_d) ? PM_SUSPEND :
                    sw_standby               ? PM_STANDBY : PM_RUN;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_q    <= PM_RESET;
            hw_susp_q <= 1'b0;
            sw_susp_q <= 1'b0;
        end else if (ce) begin
            mode_q    <= mode_d;
            hw_susp_q <= hw_susp_d;
            sw_susp_q <= sw_susp_d;
        end
    end

    assign pad_mode = mode_q;
    wire in_reset   = (mode_q == PM_RESET);
    wire in_suspend = (mode_q == PM_SUSPEND);
    wire in_hw_susp = in_suspend && hw_susp_q;
    wire slow_ref   = in_suspend && !sr_sync_q[1];

    // Slow refresh sequencer.
    logic [1:0] cbr_cas_n;
    logic       cbr_ras_n;
    cbr_refresh_timer u_refresh (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .enable (slow_ref),
        .cas_n  (cbr_cas_n),
        .ras_n  (cbr_ras_n),
        .tick   ()
    );

    // Memory strobes per condition.
    assign column_strobe_n = in_reset           ? STROBES_HIGH :
                             (in_suspend && sr_sync_q[1]) ? '0 :
                             in_suspend         ? cbr_cas_n    : core_cas_n;
    assign row_strobe_n    = in_reset           ? 1'b1 :
                             (in_suspend && sr_sync_q[1]) ? 1'b0 :
                             in_suspend         ? cbr_ras_n : core_ras_n;
    assign write_strobe_n  = (in_reset || in_suspend) ? STROBES_HIGH : core_we_n;
    assign mem_req_gated   = core_mem_req && !in_suspend && !in_reset;

    // Input masking: ignored inputs read as high.
    wire vport_ok = video_port_enable_bit && (video_port_mode_field == VPORT_MODE_REQUIRED);
    assign video_port_in = (!vport_ok || in_suspend || in_reset) ? 8'hFF : vport_sync_q;
    assign osc_in        = (in_suspend && ext_sync_q[1]) ? 1'b1 : osc_sync_q[1];
    assign bus_ctl_in    = in_hw_susp ? 4'hF : bus_ctl_pins;

    // Interrupt pad: open-drain style, floats in hardware suspend and reset.
    assign host_interrupt_n    = 1'b0;
    assign host_interrupt_oe_n = !(core_host_interrupt_n && !in_hw_susp && !in_reset);

    // Sustained-tristate target responses: drive high one clock before float,
    // and wait two idle clocks before driving again.
    wire resp_allow = core_resp_drive && !in_hw_susp && !in_reset;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            resp_drive_q   <= 1'b0;
            resp_release_q <= 1'b0;
            resp_gap_q     <= 1'b0;
            resp_hold_q    <= 3'h7;
        end else if (ce) begin
            resp_drive_q   <= resp_allow && !resp_release_q && !resp_gap_q;
            resp_release_q <= resp_drive_q && !resp_allow;
            resp_gap_q     <= resp_release_q;
            resp_hold_q    <= (resp_allow && !resp_release_q && !resp_gap_q) ? core_resp_n : 3'h7;
        end
    end

    assign resp_n    = resp_release_q ? 3'h7 : resp_hold_q;
    assign resp_oe_n = !(resp_drive_q || resp_release_q);

    release_high_a: assert property (@(posedge clk) disable iff (!arst_n)
        (ce && resp_drive_q && !resp_allow) |=> (!resp_oe_n && resp_n == 3'h7))
        else $error("response released without high cycle");

    turnaround_gap_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(resp_oe_n) |=> resp_oe_n)
        else $error("response driven again without idle clock");

    reset_strobes_a: assert property (@(posedge clk) disable iff (!arst_n)
        in_reset |-> (column_strobe_n == STROBES_HIGH && write_strobe_n == STROBES_HIGH))
        else $error("memory strobes not high in reset");

    suspend_write_a: assert property (@(posedge clk) disable iff (!arst_n)
        in_suspend |-> (write_strobe_n == STROBES_HIGH && !mem_req_gated))
        else $error("write strobe or access during suspend");

    hw_float_a: assert property (@(posedge clk) disable iff (!arst_n)
        in_hw_susp |-> (host_interrupt_oe_n && bus_ctl_in == 4'hF))
        else $error("interrupt driven or inputs live in hardware suspend");

    self_refresh_a: assert property (@(posedge clk) disable iff (!arst_n)
        (in_suspend && sr_sync_q[1]) |-> (column_strobe_n == '0 && !row_strobe_n))
        else $error("strobes not low with self refresh");

    osc_ignore_a: assert property (@(posedge clk) disable iff (!arst_n)
        (in_suspend && ext_sync_q[1]) |-> osc_in)
        else $error("oscillator not masked in suspend");

    vport_mask_a: assert property (@(posedge clk) disable iff (!arst_n)
        !video_port_enable_bit |-> (video_port_in == 8'hFF))
        else $error("video port inputs not forced high");

    mode_priority_a: assert property (@(posedge clk) disable iff (!arst_n)
        (ce && hws_sync_q[1]) |=> (mode_q == PM_SUSPEND))
        else $error("hardware suspend not registered");

    refresh_only_a: assert property (@(posedge clk) disable iff (!arst_n)
        slow_ref |-> (!mem_req_gated && row_strobe_n == cbr_ras_n))
        else $error("memory activity besides slow refresh");

    suspend_cas_a: assert property (@(posedge clk) disable iff (!arst_n)
        slow_ref |-> (column_strobe_n == cbr_cas_n))
        else $error("column strobes not from refresh sequencer");

    standby_cas_a: assert property (@(posedge clk) disable iff (!arst_n)
        (mode_q == PM_STANDBY) |-> (column_strobe_n == core_cas_n))
        else $error("column strobes not live in standby");

    standby_we_a: assert property (@(posedge clk) disable iff (!arst_n)
        (mode_q == PM_STANDBY) |-> (write_strobe_n == core_we_n))
        else $error("write strobes not live in standby");

    drive_granted_a: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(resp_oe_n) |-> $past(resp_allow))
        else $error("responses driven without a grant");

    release_level_a: assert property (@(posedge clk) disable iff (!arst_n)
        resp_release_q |-> (resp_n == 3'h7 && !resp_oe_n))
        else $error("release cycle not driven high");

    gap_float_a: assert property (@(posedge clk) disable iff (!arst_n)
        resp_gap_q |-> resp_oe_n)
        else $error("responses driven in turnaround clock");

    reset_float_a: assert property (@(posedge clk) disable iff (!arst_n)
        in_reset |-> (resp_oe_n && host_interrupt_oe_n))
        else $error("outputs driven in reset");

    hw_resp_float_a: assert property (@(posedge clk) disable iff (!arst_n)
        (in_hw_susp && $past(in_hw_susp) && $past(ce)) |-> !resp_drive_q)
        else $error("responses driven in hardware suspend");

    host_interrupt_n_normal_a: assert property (@(posedge clk) disable iff (!arst_n)
        (core_host_interrupt_n && !in_hw_susp && !in_reset) |-> !host_interrupt_oe_n)
        else $error("interrupt not driven when allowed");

    inputs_ignored_a: assert property (@(posedge clk) disable iff (!arst_n)
        (!vport_ok || in_suspend || in_reset) |-> (video_port_in == 8'hFF))
        else $error("ignored video inputs not forced high");

    bus_live_a: assert property (@(posedge clk) disable iff (!arst_n)
        !in_hw_susp |-> (bus_ctl_in == bus_ctl_pins))
        else $error("bus control inputs masked outside hardware suspend");

    osc_live_a: assert property (@(posedge clk) disable iff (!arst_n)
        !in_suspend |-> (osc_in == osc_sync_q[1]))
        else $error("oscillator masked outside suspend");

    reset_first_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(arst_n) |-> in_reset)
        else $error("pad condition left reset too early");

    mode_freeze_a: assert property (@(posedge clk) disable iff (!arst_n)
        !ce |=> $stable(mode_q))
        else $error("pad condition changed with clock enable low");

    soft_suspend_a: assert property (@(posedge clk) disable iff (!arst_n)
        (ce && !hws_sync_q[1] && sw_suspend) |=> (mode_q == PM_SUSPEND && !hw_susp_q))
        else $error("software suspend not registered");

    standby_sel_a: assert property (@(posedge clk) disable iff (!arst_n)
        (ce && !hws_sync_q[1] && !sw_suspend && sw_standby) |=> (mode_q == PM_STANDBY))
        else $error("standby not registered");

endmodule : power_mode_pad_state_control
`default_nettype wire

// file: hw/pad_state_pkg.sv
// Constants for the power-mode pad state controller.
// Assumes a 125 MHz core clock and a separate 32 kHz-class suspend link clock.
package pad_state_pkg;

    localparam int unsigned CLK_MHZ            = 125;
    localparam int unsigned REFRESH_PERIOD_US  = 30;
    localparam int unsigned REFRESH_CYCLES     = REFRESH_PERIOD_US * CLK_MHZ;
    localparam int unsigned REFRESH_CNT_W      = 13;
    localparam logic [REFRESH_CNT_W-1:0] REFRESH_LAST = REFRESH_CNT_W'(REFRESH_CYCLES - 1);
    localparam int unsigned CBR_STEP_CYCLES    = 4;
    localparam logic [2:0] VPORT_MODE_REQUIRED = 3'h1;
    localparam int unsigned STROBE_W           = 2;
    localparam logic [1:0] STROBES_HIGH        = 2'h3;

    typedef enum logic [1:0] {
        PM_RESET   = 2'b00,
        PM_RUN     = 2'b01,
        PM_STANDBY = 2'b11,
        PM_SUSPEND = 2'b10
    } pad_mode_t;

    typedef enum logic [1:0] {
        CBR_IDLE = 2'b00,
        CBR_CAS  = 2'b01,
        CBR_RAS  = 2'b11,
        CBR_DONE = 2'b10
    } cbr_state_t;

endpackage : pad_state_pkg

// file: hw/cbr_refresh_timer.sv
// Slow-refresh CBR sequencer: one CAS-before-RAS cycle per refresh period.
// Assumes enable is synchronous to clk and already registered.
`timescale 1ns/100ps
`default_nettype none
module cbr_refresh_timer
    import pad_state_pkg::*;
(
    input  wire logic                clk,       // Core clock.
    input  wire logic                arst_n,    // Async reset, active low.
    input  wire logic                ce,        // Clock enable.
    input  wire logic                enable,    // Slow refresh active.
    output logic [pad_state_pkg::STROBE_W-1:0] cas_n, // Column strobes.
    output logic                     ras_n,     // Row strobe.
    output logic                     tick       // One-cycle pulse per refresh.
);
    import pad_state_pkg::*;

    logic [REFRESH_CNT_W-1:0] cnt_q;
    logic [1:0]               step_q;
    cbr_state_t               state_q;
    wire                      period_end = (cnt_q == REFRESH_LAST);
    wire                      step_end   = (step_q == 2'(CBR_STEP_CYCLES - 1));

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q   <= '0;
            step_q  <= '0;
            state_q <= CBR_IDLE;
        end else if (ce) begin
            cnt_q  <= (!enable || period_end) ? '0 : cnt_q + 1'b1;
            step_q <= (state_q == CBR_IDLE) ? '0 : step_q + 1'b1;
            case (state_q)
                CBR_IDLE: if (enable && period_end) state_q <= CBR_CAS;
                CBR_CAS:  if (step_end) state_q <= CBR_RAS;
                CBR_RAS:  if (step_end) state_q <= CBR_DONE;
                default:  if (step_end) state_q <= CBR_IDLE;
            endcase
        end
    end

    // CAS falls first, then RAS, so the DRAM sees a CBR refresh rather than an access.
    assign cas_n = (state_q == CBR_CAS || state_q == CBR_RAS) ? '0 : STROBES_HIGH;
    assign ras_n = (state_q != CBR_RAS);
    assign tick  = ce && (state_q == CBR_IDLE) && enable && period_end;

    slow_refresh_timing_a: assert property (@(posedge clk) disable iff (!arst_n)
        (ce && state_q == CBR_IDLE && enable && period_end) |=> (state_q == CBR_CAS))
        else $error("refresh did not start at period end");

    cbr_order_a: assert property (@(posedge clk) disable iff (!arst_n)
        !ras_n |-> (cas_n == '0))
        else $error("row strobe low without column strobe low");

endmodule : cbr_refresh_timer
`default_nettype wire

// file: verif/dram_host_model.sv
// Far side of the pads: host bus pull-ups on released lines and a DRAM refresh watcher.
// Assumes the pad outputs of the power-mode pad state controller.
`timescale 1ns/100ps
`default_nettype none
module dram_host_model (
    input  wire logic       clk,                 // Bus clock.
    input  wire logic [1:0] column_strobe_n,     // Column strobe pads.
    input  wire logic       row_strobe_n,        // Row strobe pad.
    input  wire logic [2:0] resp_n,              // Response pad levels.
    input  wire logic       resp_oe_n,           // Response enable, low drives.
    input  wire logic       host_interrupt_n,    // Interrupt pad level.
    input  wire logic       host_interrupt_oe_n, // Interrupt enable, low drives.
    output logic [2:0]      resp_wire,           // Resolved response lines.
    output logic            host_interrupt_n_wire,           // Resolved interrupt line.
    output var int          cbr_seen,            // Row falls with a column strobe low.
    output var int          ras_first            // Row falls with column strobes high.
);
    logic ras_q = 1'b1;
    int   seen_q = 0;
    int   first_q = 0;
    assign cbr_seen  = seen_q;
    assign ras_first = first_q;
    // Released lines sit at the pull-up level, never at the last driven value.
    assign resp_wire = resp_oe_n ? 3'h7 : resp_n;
    assign host_interrupt_n_wire = host_interrupt_oe_n ? 1'b1 : host_interrupt_n;
    always @(posedge clk) begin
        ras_q <= row_strobe_n;
        if (ras_q && !row_strobe_n) begin
            if (column_strobe_n != 2'h3) seen_q <= seen_q + 1;
            else first_q <= first_q + 1;
        end
    end
endmodule : dram_host_model
`default_nettype wire

// file: verif/tb.sv
// Testbench for the power-mode pad state controller.
// Assumes the design package and the far-side model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import pad_state_pkg::*;
    logic       clk, arst_n, ce, susp_clk, sw_standby, sw_suspend, hw_suspend_pin, ext_32k_used;
    logic       self_refresh, video_port_enable_bit, reference_oscillator_in, core_ras_n, core_mem_req;
    logic       core_host_interrupt_n, core_resp_drive, osc_in, mem_req_gated, row_strobe_n, host_interrupt_n;
    logic       host_interrupt_oe_n, resp_oe_n, susp_heartbeat, host_interrupt_n_wire;
    logic [2:0] video_port_mode_field, core_resp_n, resp_n, resp_wire;
    logic [7:0] video_port_pins, video_port_in;
    logic [3:0] bus_ctl_pins, bus_ctl_in;
    logic [1:0] core_cas_n, core_we_n, column_strobe_n, write_strobe_n;
    pad_mode_t  pad_mode;
    int         cbr_seen, ras_first, n_fail, checks_done;
    time        t0;

    power_mode_pad_state_control u_dut (.clk, .arst_n, .ce, .susp_clk, .sw_standby, .sw_suspend,
        .hw_suspend_pin, .ext_32k_used, .self_refresh, .video_port_enable_bit, .video_port_mode_field,
        .video_port_pins, .video_port_in, .reference_oscillator_in, .osc_in, .bus_ctl_pins, .bus_ctl_in,
        .core_cas_n, .core_ras_n, .core_we_n, .core_mem_req, .mem_req_gated, .column_strobe_n,
        .row_strobe_n, .write_strobe_n, .core_host_interrupt_n, .host_interrupt_n, .host_interrupt_oe_n,
        .core_resp_n, .core_resp_drive, .resp_n, .resp_oe_n, .susp_heartbeat, .pad_mode);
    dram_host_model u_far (.clk, .column_strobe_n, .row_strobe_n, .resp_n, .resp_oe_n,
        .host_interrupt_n, .host_interrupt_oe_n, .resp_wire, .host_interrupt_n_wire, .cbr_seen, .ras_first);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // The suspend clock runs free at its own phase.
    initial begin
        susp_clk = 1'b0;
        #3;
        forever #40 susp_clk = ~susp_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic set_mode(input logic stby, input logic susp, input logic hw);
        sw_standby = stby;
        sw_suspend = susp;
        hw_suspend_pin = hw;
        cyc(6);
    endtask : set_mode

    task automatic t_reset;
        chk(16'(pad_mode), 16'(PM_RESET), "reset mode");
        chk(16'(column_strobe_n), 16'h0003, "reset cas");
        chk(16'(write_strobe_n), 16'h0003, "reset we");
        chk({resp_oe_n, host_interrupt_oe_n}, 16'h0003, "reset float");
    endtask : t_reset

    task automatic t_standby;
        core_we_n = 2'h1;
        core_cas_n = 2'h2;
        set_mode(1'b1, 1'b0, 1'b0);
        chk(16'(pad_mode), 16'(PM_STANDBY), "standby mode");
        chk(16'(write_strobe_n), 16'h0001, "standby we");
        chk({column_strobe_n, row_strobe_n}, 16'h0005, "standby cas");
        chk({mem_req_gated, host_interrupt_n_wire, bus_ctl_in}, 16'h0025, "standby bus");
        video_port_pins = 8'h5a;
        video_port_enable_bit = 1'b1;
        cyc(2);
        chk(16'(video_port_in), 16'h005a, "vport on");
        video_port_mode_field = 3'h2;
        cyc(1);
        chk(16'(video_port_in), 16'h00ff, "vport bad mode");
        video_port_mode_field = 3'h1;
        video_port_enable_bit = 1'b0;
        cyc(1);
        chk(16'(video_port_in), 16'h00ff, "vport off");
    endtask : t_standby

    task automatic t_resp;
        core_resp_drive = 1'b1;
        cyc(1);
        chk({resp_oe_n, resp_wire}, 16'h0002, "resp drive");
        core_resp_drive = 1'b0;
        cyc(1);
        chk({resp_oe_n, resp_n}, 16'h0007, "resp high first");
        cyc(1);
        chk({resp_oe_n, resp_wire}, 16'h000f, "resp float");
        core_resp_drive = 1'b1;
        cyc(1);
        chk(16'(resp_oe_n), 16'h0001, "resp turnaround");
        cyc(3);
        chk(16'(resp_oe_n), 16'h0000, "resp redrive");
        core_resp_drive = 1'b0;
        cyc(3);
    endtask : t_resp

    task automatic t_sw_susp;
        ext_32k_used = 1'b1;
        reference_oscillator_in = 1'b0;
        video_port_enable_bit = 1'b1;
        set_mode(1'b0, 1'b1, 1'b0);
        chk(16'(pad_mode), 16'(PM_SUSPEND), "susp mode");
        chk({write_strobe_n, mem_req_gated}, 16'h0006, "susp we");
        chk({osc_in, video_port_in}, 16'h01ff, "susp ignored");
        chk(16'(host_interrupt_oe_n), 16'h0000, "susp host_interrupt_n");
        ext_32k_used = 1'b0;
        cyc(6);
        chk(16'(osc_in), 16'h0000, "osc used");
    endtask : t_sw_susp

    task automatic t_refresh;
        for (int i = 0; i < 4000 && column_strobe_n === 2'h3; i++) cyc(1);
        t0 = $time;
        chk(16'(row_strobe_n), 16'h0001, "cas leads");
        cyc(CBR_STEP_CYCLES);
        chk({row_strobe_n, write_strobe_n}, 16'h0003, "ras follows");
        for (int i = 0; i < 20 && column_strobe_n !== 2'h3; i++) cyc(1);
        for (int i = 0; i < 4000 && column_strobe_n === 2'h3; i++) cyc(1);
        chk(16'(($time - t0) / 8), 16'(REFRESH_CYCLES), "refresh period");
        chk({cbr_seen > 0, ras_first == 0}, 16'h0003, "cbr order");
        self_refresh = 1'b1;
        cyc(5);
        chk({column_strobe_n, row_strobe_n}, 16'h0000, "self refresh");
        self_refresh = 1'b0;
    endtask : t_refresh

    task automatic t_hw_susp;
        core_resp_drive = 1'b1;
        bus_ctl_pins = 4'h0;
        set_mode(1'b0, 1'b0, 1'b1);
        chk(16'(pad_mode), 16'(PM_SUSPEND), "hw mode");
        chk({resp_oe_n, host_interrupt_oe_n, host_interrupt_n_wire}, 16'h0007, "hw float");
        chk({bus_ctl_in, write_strobe_n}, 16'h003f, "hw ignored");
        core_resp_drive = 1'b0;
    endtask : t_hw_susp

    task automatic t_prio;
        int hb;
        hb = 0;
        repeat (400) begin
            cyc(1);
            hb += int'(susp_heartbeat);
        end
        chk(16'(hb >= 38 && hb <= 82), 16'h0001, "heartbeat");
        arst_n = 1'b0;
        #1;
        t_reset();
        cyc(2);
        arst_n = 1'b1;
        cyc(6);
        chk(16'(pad_mode), 16'(PM_SUSPEND), "after reset");
        ce = 1'b0;
        hw_suspend_pin = 1'b0;
        cyc(6);
        chk(16'(pad_mode), 16'(PM_SUSPEND), "frozen");
        ce = 1'b1;
        cyc(4);
        chk(16'(pad_mode), 16'(PM_RUN), "run mode");
    endtask : t_prio

    task automatic results;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    initial begin
        #400_000;
        n_fail++;
        results();
    end

    initial begin
        {arst_n, sw_standby, sw_suspend, hw_suspend_pin, ext_32k_used, self_refresh} = 6'h00;
        {video_port_enable_bit, reference_oscillator_in, core_mem_req, core_resp_drive} = 4'h7;
        {ce, core_ras_n, core_host_interrupt_n} = 3'h7;
        video_port_mode_field = 3'h1;
        core_resp_n = 3'h2;
        video_port_pins = 8'h00;
        bus_ctl_pins = 4'h5;
        core_cas_n = 2'h3;
        core_we_n = 2'h3;
        n_fail = 0;
        checks_done = 0;
        core_resp_drive = 1'b0;
        repeat (16) @(negedge clk);
        t_reset();
        arst_n = 1'b1;
        t_standby();
        t_resp();
        t_sw_susp();
        t_refresh();
        t_hw_susp();
        t_prio();
        results();
    end
endmodule : tb
`default_nettype wire
